//--- src/rtc_pin_trim.v
`timescale 1ns/1ps
`include "rtc_trim_defines.vh"
module rtc_pin_trim (
	input wire CLK,
	input wire RST,
	input wire [7:0] ADDR,
	input wire [7:0] WDATA,
	input wire WE,
	input wire ALARM0_MATCH,
	input wire ALARM1_MATCH,
	input wire BACKUP_POWER,
	output reg [7:0] RDATA,
	output reg MULTI_FUNCTION_PIN,
	output reg MULTI_FUNCTION_PIN_OE,
	output reg SECOND_TICK,
	output reg MINUTE_TICK
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [2:0] sync1_q;
	reg [2:0] sync2_q;
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {BACKUP_POWER, ALARM1_MATCH, ALARM0_MATCH};
			sync2_q <= sync1_q;
		end
	end
	wire backup = sync2_q[2];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	wire [7:0] ctl;
	wire [7:0] trim;
	wire ctl_we = WE && !backup && ADDR == `CLOCK_CONTROL_ADDR;
	wire trim_we = WE && !backup && ADDR == `OSCILLATOR_TRIM_ADDR;
	trim_reg_byte #(.INIT(`CTL_RESET)) u_ctl (
		.clk(CLK),
		.rst(RST),
		.we(ctl_we),
		.wdata(WDATA),
		.q(ctl)
	);
	trim_reg_byte #(.INIT(`TRIM_RESET)) u_trim (
		.clk(CLK),
		.rst(RST),
		.we(trim_we),
		.wdata(WDATA),
		.q(trim)
	);
	// Alarm weekday bytes: polarity shared, flags set by match
	reg pol_q;
	reg [1:0] flag_q;
	reg [5:0] wk0_q;
	reg [5:0] wk1_q;
	wire w0 = WE && !backup && ADDR == `ALARM0_WKDAY_ADDR;
	wire w1 = WE && !backup && ADDR == `ALARM1_WKDAY_ADDR;
	// Match sets win over a software clear in the same cycle
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			pol_q <= 1'b0;
			flag_q <= 2'h0;
			wk0_q <= 6'h00;
			wk1_q <= 6'h00;
		end else begin
			if (w0 || w1) begin
				pol_q <= WDATA[`WKDAY_POL];
			end
			if (w0) begin
				wk0_q <= {WDATA[6:4], WDATA[2:0]};
			end
			if (w1) begin
				wk1_q <= {WDATA[6:4], WDATA[2:0]};
			end
			flag_q[0] <= sync2_q[0] | (w0 ? WDATA[`WKDAY_FLAG] : flag_q[0]);
			flag_q[1] <= sync2_q[1] | (w1 ? WDATA[`WKDAY_FLAG] : flag_q[1]);
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	reg [7:0] rd_d;
	always @* begin
		case (ADDR)
			`CLOCK_CONTROL_ADDR: rd_d = ctl;
			`OSCILLATOR_TRIM_ADDR: rd_d = trim;
			`ALARM0_WKDAY_ADDR: rd_d = {pol_q, wk0_q[5:3], flag_q[0], wk0_q[2:0]};
			`ALARM1_WKDAY_ADDR: rd_d = {pol_q, wk1_q[5:3], flag_q[1], wk1_q[2:0]};
			default: rd_d = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Trimmed prescaler
	// ----------------------------------------
	// Phase 0 idles, then the trim event adds or removes ticks
	localparam [2:0] PH_RUN = 3'b001;
	localparam [2:0] PH_ADD = 3'b010;
	localparam [2:0] PH_SUB = 3'b100;
	reg [2:0] state_q;
	reg [14:0] pre_q;
	reg [5:0] sec_q;
	reg [7:0] left_q;
	wire coarse = ctl[`CTL_COARSE];
	wire [7:0] cycles = {trim[6:0], 1'b0};
	wire last_sec = sec_q == `SECONDS_PER_MIN;
	// Add phase steps two ticks a cycle, sub phase holds the count
	wire [15:0] pre_step = state_q == PH_SUB ? 16'h0000 : (state_q == PH_ADD ? 16'h0002 : 16'h0001);
	wire [15:0] pre_next = {1'b0, pre_q} + pre_step;
	// Carry out, so a two-tick step cannot skip the second boundary
	wire wrap = pre_next[15];
	wire slot_edge = pre_next[`COARSE_SLOT_BIT] != pre_q[`COARSE_SLOT_BIT];
	// Boundary: minute rollover or each 1/128 s slot entered
	wire boundary = coarse ? slot_edge : (wrap && last_sec);
	wire start = boundary && trim[6:0] != 7'h00;
	// Runs regardless of supply, so trim holds on backup
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_q <= PH_RUN;
			pre_q <= 15'h0000;
			sec_q <= 6'h00;
			left_q <= 8'h00;
			SECOND_TICK <= 1'b0;
			MINUTE_TICK <= 1'b0;
		end else begin
			SECOND_TICK <= wrap;
			MINUTE_TICK <= wrap && last_sec;
			pre_q <= pre_next[14:0];
			if (wrap) begin
				sec_q <= last_sec ? 6'h00 : sec_q + 6'h01;
			end
			// A slot entered while still adding restarts the count: strong coarse trims saturate
			if (start) begin
				left_q <= cycles;
				state_q <= trim[`TRIM_SIGN] ? PH_ADD : PH_SUB;
			end else begin
				case (state_q)
					PH_RUN: state_q <= PH_RUN;
					PH_ADD, PH_SUB: begin
						left_q <= left_q - 8'h01;
						if (left_q == 8'h01) begin
							state_q <= PH_RUN;
						end
					end
					default: state_q <= PH_RUN;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Pin function select
	// ----------------------------------------
	reg sqw_bit;
	reg pin_d;
	reg oe_d;
	wire alm_pin = ctl[`CTL_ALM0_EN] && ctl[`CTL_ALM1_EN]
		? (pol_q ? (flag_q[0] | flag_q[1]) : ~(flag_q[0] & flag_q[1]))
		: (pol_q ? (ctl[`CTL_ALM0_EN] ? flag_q[0] : flag_q[1])
			: ~(ctl[`CTL_ALM0_EN] ? flag_q[0] : flag_q[1]));
	always @* begin
		case (ctl[1:0])
			2'b00: sqw_bit = pre_q[14];
			2'b01: sqw_bit = pre_q[2];
			2'b10: sqw_bit = pre_q[1];
			default: sqw_bit = pre_q[0];
		endcase
		if (ctl[`CTL_SQW_EN]) begin
			// Square wave owns the pin; dropped on backup
			pin_d = coarse ? pre_q[`COARSE_SLOT_BIT] : sqw_bit;
			oe_d = !backup;
		end else if (ctl[`CTL_ALM0_EN] || ctl[`CTL_ALM1_EN]) begin
			pin_d = alm_pin;
			oe_d = 1'b1;
		end else begin
			pin_d = ctl[`CTL_GP_LEVEL];
			oe_d = !backup;
		end
	end
	// Registered outputs; one cycle after the deciding bits
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			RDATA <= 8'h00;
			MULTI_FUNCTION_PIN <= 1'b1;
			MULTI_FUNCTION_PIN_OE <= 1'b0;
		end else begin
			RDATA <= rd_d;
			MULTI_FUNCTION_PIN <= pin_d;
			MULTI_FUNCTION_PIN_OE <= oe_d;
		end
	end
endmodule

//--- src/rtc_trim_defines.vh
`ifndef RTC_TRIM_DEFINES_VH
`define RTC_TRIM_DEFINES_VH
// Register offsets on the byte-wide register port
`define CLOCK_CONTROL_ADDR 8'h07
`define OSCILLATOR_TRIM_ADDR 8'h08
`define ALARM0_WKDAY_ADDR 8'h0D
`define ALARM1_WKDAY_ADDR 8'h14
// Clock control fields
`define CTL_GP_LEVEL 7
`define CTL_SQW_EN 6
`define CTL_ALM1_EN 5
`define CTL_ALM0_EN 4
`define CTL_EXT_CLK 3
`define CTL_COARSE 2
`define CTL_RESET 8'h80
// Trim fields
`define TRIM_SIGN 7
`define TRIM_RESET 8'h00
// Alarm weekday fields
`define WKDAY_POL 7
`define WKDAY_FLAG 3
`define WKDAY_RESET 8'h00
// Prescaler: 32768 ticks per second, 256 per 1/128 s
`define PRESCALE_LAST 15'h7FFF
`define COARSE_SLOT_BIT 8
`define SECONDS_PER_MIN 6'h3B
`endif

//--- src/trim_reg_byte.v
`timescale 1ns/1ps
// One byte of register storage with reset value
module trim_reg_byte #(
	parameter [7:0] INIT = 8'h00
) (
	input wire clk,
	input wire rst,
	input wire we,
	input wire [7:0] wdata,
	output reg [7:0] q
);
	// Write updates, reset restores
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= INIT;
		end else if (we) begin
			q <= wdata;
		end
	end
endmodule

//--- verification/pin_pullup.sv
`timescale 1ns/1ps
// -------------------------
// Pin watcher with pull-up
// -------------------------
module pin_pullup (
	input wire oe,
	input wire drv,
	output wire level
);
	// Released pin rises to the pull-up, never keeps the old value
	assign level = oe ? drv : 1'b1;
endmodule

//--- verification/rtc_pin_trim_sva.sv
`timescale 1ns/1ps
module rtc_pin_trim_chk (
	input wire CLK,
	input wire RST,
	input wire [7:0] ADDR,
	input wire [7:0] WDATA,
	input wire WE,
	input wire ALARM0_MATCH,
	input wire ALARM1_MATCH,
	input wire BACKUP_POWER,
	input wire [7:0] RDATA,
	input wire MULTI_FUNCTION_PIN,
	input wire MULTI_FUNCTION_PIN_OE,
	input wire SECOND_TICK,
	input wire MINUTE_TICK
);
	// Control shadow; writes dropped once the two-stage supply flag is high
	reg [7:0] ctl_q;
	reg bk1_q;
	reg bk2_q;
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctl_q <= 8'h80;
			bk1_q <= 1'b0;
			bk2_q <= 1'b0;
		end else begin
			bk1_q <= BACKUP_POWER;
			bk2_q <= bk1_q;
			if (WE && ADDR == 8'h07 && !bk2_q)
				ctl_q <= WDATA;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	a_sec_one: assert property (SECOND_TICK |=> !SECOND_TICK) else $error("tick wide");
	a_min_one: assert property (MINUTE_TICK |=> !MINUTE_TICK) else $error("minute wide");
	a_ctl_read: assert property (ADDR == 8'h07 |=> RDATA == $past(ctl_q)) else $error("ctl read");
	a_hole_read: assert property (!(ADDR inside {8'h07, 8'h08, 8'h0D, 8'h14}) |=> RDATA == 8'h00)
		else $error("hole read");
	a_trim_read: assert property ((WE && ADDR == 8'h08 && !bk2_q)
		##1 ADDR == 8'h08 |=> RDATA == $past(WDATA, 2)) else $error("trim read");
	a_gp_level: assert property (ctl_q[6:4] == 3'b000 && $stable(ctl_q) && !bk2_q
		|=> MULTI_FUNCTION_PIN == $past(ctl_q[7]) && MULTI_FUNCTION_PIN_OE) else $error("gp level");
	a_gp_backup: assert property (ctl_q[6:4] == 3'b000 && $stable(ctl_q) && bk2_q |=> !MULTI_FUNCTION_PIN_OE)
		else $error("gp on backup");
	a_alarm_drive: assert property (ctl_q[5:4] != 2'b00 && !ctl_q[6] && $stable(ctl_q) |=> MULTI_FUNCTION_PIN_OE)
		else $error("alarm idle");
	a_min_sec: assert property (MINUTE_TICK |-> SECOND_TICK) else $error("minute off second");
	a_sqw_drive: assert property (ctl_q[6] && $stable(ctl_q) && !bk2_q |=> MULTI_FUNCTION_PIN_OE)
		else $error("square wave idle");
endmodule
bind rtc_pin_trim rtc_pin_trim_chk i_chk (.*);

//--- verification/rtc_pin_trim_tb.sv
`timescale 1ns/1ps
module rtc_pin_trim_tb;
	logic clk = 0, rst = 1, we = 0, m0 = 0, m1 = 0, bk = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00;
	wire [7:0] rdata;
	wire p_out, p_oe, sec, mnt, lvl;
	int n_fail = 0, checks_done = 0, cyc = 0, i, n, en, pol, f0, f1, gp, x;
	rtc_pin_trim i_rtc_pin_trim (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WE(we), .ALARM0_MATCH(m0),
		.ALARM1_MATCH(m1), .BACKUP_POWER(bk), .RDATA(rdata), .MULTI_FUNCTION_PIN(p_out), .MULTI_FUNCTION_PIN_OE(p_oe),
		.SECOND_TICK(sec), .MINUTE_TICK(mnt));
	pin_pullup i_pin_pullup (.oe(p_oe), .drv(p_out), .level(lvl));
	initial forever #50 clk = ~clk;
	// Hang guard, about three fifths above the longest run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			n_fail++;
			finish_test;
		end
	end
	// --------------
	// Bus helpers
	// --------------
	task step(input int k);
		repeat (k) @(posedge clk);
		#10;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %0t got %0h want %0h", $time, s, e);
		end
	endtask
	// Strobe stays up across back-to-back writes
	task wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		we = 1;
		step(1);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		we = 0;
		addr = a;
		step(2);
		chk(rdata, e);
	endtask
	// Pin period in cycles, measured rise to rise after the new setting
	task period(input logic [7:0] c, input logic [7:0] t, input int e);
		int k;
		int h;
		wr(8'h07, c);
		wr(8'h08, t);
		we = 0;
		for (k = 0; k < 2000 && lvl !== 1'b0; k++)
			step(1);
		for (k = 0; k < 2000 && lvl !== 1'b1; k++)
			step(1);
		for (k = 0; k < 2000 && lvl !== 1'b0; k++)
			step(1);
		for (h = 0; h < 2000 && lvl !== 1'b1; h++)
			step(1);
		chk(k + h, e);
	endtask
	task finish_test;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		i = $urandom(32'h436B61FA);
		step(6);
		rst = 0;
		rd(8'h07, 8'h80);
		rd(8'h08, 8'h00);
		rd(8'h00, 8'h00);
		// Level output and every alarm output mode, random flags, polarity and supply
		for (n = 0; n < 48; n++) begin
			en = n % 4;
			pol = $urandom % 2;
			f0 = $urandom % 2;
			f1 = $urandom % 2;
			gp = $urandom % 2;
			wr(8'h0D, {pol[0], 7'h00});
			wr(8'h14, {pol[0], 7'h00});
			wr(8'h07, {gp[0], 1'b0, en[1:0], 4'h0});
			rd(8'h07, {gp[0], 1'b0, en[1:0], 4'h0});
			m0 = f0[0];
			m1 = f1[0];
			step(1);
			m0 = 0;
			m1 = 0;
			bk = $urandom % 2;
			step(6);
			x = en == 0 ? gp : en == 3 ? (pol ? f0 | f1 : !(f0 & f1)) : ((en == 1 ? f0 : f1) == pol);
			chk({30'h0, p_oe, lvl}, (en == 0 && bk) ? 1 : 2 + x);
			rd(8'h0D, {pol[0], 3'h0, f0[0], 3'h0});
			bk = 0;
			step(4);
		end
		// Square wave over alarms; coarse slot clock with zero, sub and add trims
		period(8'h71, 8'h00, 8);
		period(8'h74, 8'h80, 512);
		period(8'h74, 8'h01, 516);
		period(8'h74, 8'h81, 508);
		wr(8'h07, 8'h04);
		wr(8'h08, 8'h00);
		wr(8'h08, 8'hA0);
		rd(8'h08, 8'hA0);
		bk = 1;
		for (i = 0; i < 40000 && sec !== 1'b1; i++)
			step(1);
		n = 0;
		do begin
			step(1);
			n++;
		end while (sec !== 1'b1 && n < 40000);
		chk(n, 32768 - 128 * 2 * 32);
		finish_test;
	end
endmodule
